/* File: core/pcsp_pkg.sv */
// constants and carrier types for the codec pcm and control serial ports
// assumes a two-byte control frame: command byte then data byte, msb first
package pcsp_pkg;
    localparam int SLOT_W = 6;
    localparam int BITCNT_W = 10;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 3;
    localparam int MAX_LATCH = 6;
    // bit positions inside the command byte
    localparam int CMD_RD_BIT = 7;
    // control register addresses
    localparam logic [2:0] A_MODE = 3'h0;
    localparam logic [2:0] A_TX_SLOT = 3'h1;
    localparam logic [2:0] A_RX_SLOT = 3'h2;
    localparam logic [2:0] A_LATCH_DIR = 3'h3;
    localparam logic [2:0] A_LATCH_VAL = 3'h4;
    // mode register fields
    localparam int M_MU_LAW = 0;
    localparam int M_DELAYED = 1;
    localparam int M_TX_EN = 2;
    localparam int M_RX_EN = 3;
    // slot register fields: slot number low, port select above it
    localparam int S_PORT = 6;
    // control frame and pcm slot bit counts
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h0f;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [BITCNT_W-1:0] CNT_MAX = 10'h3ff;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] SLOT_RST = 8'h00;
    localparam logic [7:0] TX_IDLE = 8'hff;

    typedef struct packed {
        logic mu_law;
        logic delayed;
        logic tx_en;
        logic rx_en;
        logic [SLOT_W-1:0] tx_slot;
        logic tx_port;
        logic [SLOT_W-1:0] rx_slot;
        logic rx_port;
    } pcsp_cfg_t;

    // one two-way pin group: sensed level, driven level, enable
    typedef struct packed {
        logic [MAX_LATCH-1:0] sense;
        logic [MAX_LATCH-1:0] drive;
        logic [MAX_LATCH-1:0] en;
    } pcsp_latch_t;
endpackage : pcsp_pkg

/* File: core/pcsp_codec_ports.sv */
// pcm serial ports, serial control port and interface latches of the codec
// assumes bit_clock and frame syncs come from the backplane, unrelated to
// sys_clk; control_clock is slow enough to be oversampled by sys_clk
// How it works
// - receive data sampled on bit clock falling edge
// - transmit bits launched on bit clock rising edge
// - readback shifted out on control clock rising
// - control input sampled on control clock falling
// - chip select low gates control in and out
// - slot indicator pulls low only during active slot
// - latch pin direction set by direction register
// - channel assignable to any of 64 slots in delayed mode, fixed to slot 0 otherwise
// - a-law or mu-law selected by programming
// - transmit outputs float outside assigned slot and port
// - frame sync starts slot or frame by mode
// - receive inputs ignored outside assigned slot
// - input latches captured on write, read back serially
module pcsp_codec_ports #(
    parameter int LATCH_N = 6
) (
    // system
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic master_reset,
    // pcm link
    input wire logic bit_clock,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    input wire logic rx_pcm_in_port0,
    input wire logic rx_pcm_in_port1,
    output logic [1:0] tx_pcm_out_o,
    output logic [1:0] tx_pcm_out_oe,
    output logic [1:0] slot_active_n_o,
    output logic [1:0] slot_active_n_oe,
    // serial control port
    input wire logic control_clock,
    input wire logic control_serial_in,
    input wire logic control_cs_n,
    output logic control_serial_out_o,
    output logic control_serial_out_oe,
    // interface latch pins
    input wire logic [LATCH_N-1:0] latch_pin_i,
    output logic [LATCH_N-1:0] latch_pin_o,
    output logic [LATCH_N-1:0] latch_pin_oe,
    // coder side, sys_clk domain
    input wire logic [7:0] tx_sample,
    input wire logic tx_sample_load,
    output logic [7:0] rx_sample,
    output logic rx_sample_valid,
    output logic mu_law_sel
);
    localparam int BW = pcsp_pkg::BYTE_W;

    if (LATCH_N < 1 || LATCH_N > pcsp_pkg::MAX_LATCH) begin : g_chk
        $error("LATCH_N out of range");
    end

    function automatic logic in_slot(input logic [9:0] idx,
                                     input logic [5:0] slot,
                                     input logic delayed);
        logic [5:0] want;
        want = delayed ? slot : 6'h00;
        in_slot = (idx[9] == 1'b0) && (idx[8:3] == want);
    endfunction : in_slot

    // sys domain: synchronisers
    logic [2:0] control_clock_s_q, cs_s_q;
    logic [1:0] ci_s_q, mr_s_q;
    logic [LATCH_N-1:0] lat_s1_q, lat_s2_q;
    always_ff @(posedge sys_clk) begin
        control_clock_s_q <= {control_clock_s_q[1:0], control_clock};
        cs_s_q <= {cs_s_q[1:0], control_cs_n};
        ci_s_q <= {ci_s_q[0], control_serial_in};
        mr_s_q <= {mr_s_q[0], master_reset};
        lat_s1_q <= latch_pin_i;
        lat_s2_q <= lat_s1_q;
    end

    wire rst_all = sys_rst | mr_s_q[1];
    wire cs_act = ~cs_s_q[1];
    wire control_clock_rise = control_clock_s_q[1] & ~control_clock_s_q[2] & cs_act;
    wire control_clock_fall = ~control_clock_s_q[1] & control_clock_s_q[2] & cs_act;

    // control frame receiver
    logic [4:0] cbit_q;
    logic [15:0] csh_q;
    logic [7:0] mode_q, txs_q, rxs_q;
    logic [LATCH_N-1:0] ldir_q, lval_q, lin_q;
    logic [7:0] rd_sh_q;
    logic co_q, cfg_tgl_q;
    wire [15:0] csh_d = {csh_q[14:0], ci_s_q[1]};
    wire cmd_done = control_clock_fall && cbit_q == pcsp_pkg::CMD_LAST;
    wire frm_done = control_clock_fall && cbit_q == pcsp_pkg::FRAME_LAST;
    wire [2:0] cmd_addr = csh_d[10:8];
    wire [2:0] rd_addr = csh_d[2:0];
    wire is_write = frm_done && !csh_d[8 + pcsp_pkg::CMD_RD_BIT];
    wire [7:0] wdata = csh_d[7:0];
    wire [LATCH_N-1:0] lval_w = wdata[LATCH_N-1:0];
    // output bits read back as written, input bits as last captured
    wire [LATCH_N-1:0] lat_rd_w = (lin_q & ~ldir_q) | (lval_q & ldir_q);
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (rd_addr)
            pcsp_pkg::A_MODE: rd_mux = mode_q;
            pcsp_pkg::A_TX_SLOT: rd_mux = txs_q;
            pcsp_pkg::A_RX_SLOT: rd_mux = rxs_q;
            pcsp_pkg::A_LATCH_DIR: rd_mux[LATCH_N-1:0] = ldir_q;
            pcsp_pkg::A_LATCH_VAL: rd_mux[LATCH_N-1:0] = lat_rd_w;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst_all || !cs_act) begin
            cbit_q <= '0;
            csh_q <= '0;
        end else if (control_clock_fall) begin
            csh_q <= csh_d;
            cbit_q <= (cbit_q == pcsp_pkg::FRAME_LAST) ? '0 : cbit_q + 5'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            rd_sh_q <= '0;
            co_q <= 1'b0;
        end else if (cmd_done && csh_d[pcsp_pkg::CMD_RD_BIT]) begin
            rd_sh_q <= rd_mux;
        end else if (control_clock_rise && cbit_q >= 5'h08) begin
            co_q <= rd_sh_q[7];
            rd_sh_q <= {rd_sh_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            mode_q <= pcsp_pkg::MODE_RST;
            txs_q <= pcsp_pkg::SLOT_RST;
            rxs_q <= pcsp_pkg::SLOT_RST;
            ldir_q <= '0;
            lval_q <= '0;
            lin_q <= '0;
            cfg_tgl_q <= 1'b0;
        end else if (is_write) begin
            cfg_tgl_q <= ~cfg_tgl_q;
            // input pins sampled on every write
            lin_q <= lat_s2_q;
            unique case (cmd_addr)
                pcsp_pkg::A_MODE: mode_q <= wdata;
                pcsp_pkg::A_TX_SLOT: txs_q <= wdata;
                pcsp_pkg::A_RX_SLOT: rxs_q <= wdata;
                pcsp_pkg::A_LATCH_DIR: ldir_q <= lval_w;
                pcsp_pkg::A_LATCH_VAL: lval_q <= lval_w;
                default: ;
            endcase
        end
    end
    // cmd_addr carries command bits [10:8] only
    assign control_serial_out_o = co_q;
    assign control_serial_out_oe = cs_act;
    assign latch_pin_o = lval_q;
    assign latch_pin_oe = ldir_q;
    assign mu_law_sel = mode_q[pcsp_pkg::M_MU_LAW];

    pcsp_pkg::pcsp_cfg_t cfg_w;
    assign cfg_w = '{mu_law: mode_q[pcsp_pkg::M_MU_LAW],
                     delayed: mode_q[pcsp_pkg::M_DELAYED],
                     tx_en: mode_q[pcsp_pkg::M_TX_EN],
                     rx_en: mode_q[pcsp_pkg::M_RX_EN],
                     tx_slot: txs_q[5:0],
                     tx_port: txs_q[pcsp_pkg::S_PORT],
                     rx_slot: rxs_q[5:0],
                     rx_port: rxs_q[pcsp_pkg::S_PORT]};

    // sys side of sample crossings, toggle with held data
    logic [7:0] tx_hold_q;
    logic tx_tgl_q;
    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            tx_hold_q <= pcsp_pkg::TX_IDLE;
            tx_tgl_q <= 1'b0;
        end else if (tx_sample_load) begin
            tx_hold_q <= tx_sample;
            tx_tgl_q <= ~tx_tgl_q;
        end
    end

    // link domain reset and crossings
    logic [1:0] brst_q;
    always_ff @(posedge bit_clock) brst_q <= {brst_q[0], rst_all};
    wire brst = brst_q[1];
    logic [2:0] cfg_s_q, txt_s_q;
    pcsp_pkg::pcsp_cfg_t bcfg_q;
    logic [7:0] tx_word_q;
    always_ff @(posedge bit_clock) begin
        cfg_s_q <= {cfg_s_q[1:0], cfg_tgl_q};
        txt_s_q <= {txt_s_q[1:0], tx_tgl_q};
        if (brst) begin
            bcfg_q <= '0;
            tx_word_q <= pcsp_pkg::TX_IDLE;
        end else begin
            if (cfg_s_q[2] != cfg_s_q[1]) bcfg_q <= cfg_w;
            if (txt_s_q[2] != txt_s_q[1]) tx_word_q <= tx_hold_q;
        end
    end

    // frame syncs are synchronous to bit_clock, sampled on falling edges
    logic fsx_q, fsr_q;
    logic [9:0] txc_q, rxc_q;
    wire fsx_rise = tx_frame_sync & ~fsx_q;
    wire fsr_rise = rx_frame_sync & ~fsr_q;
    wire [9:0] txc_d = fsx_rise ? '0 :
        (txc_q == pcsp_pkg::CNT_MAX ? txc_q : txc_q + 10'h001);
    wire [9:0] rxc_d = fsr_rise ? '0 :
        (rxc_q == pcsp_pkg::CNT_MAX ? rxc_q : rxc_q + 10'h001);
    wire rx_win = bcfg_q.rx_en && in_slot(rxc_d, bcfg_q.rx_slot,
                                          bcfg_q.delayed);
    wire rx_bit = bcfg_q.rx_port ? rx_pcm_in_port1 : rx_pcm_in_port0;
    logic [7:0] rsh_q, rx_word_q;
    logic rx_tgl_q;
    always_ff @(negedge bit_clock) begin
        if (brst) begin
            fsx_q <= 1'b0;
            fsr_q <= 1'b0;
            txc_q <= pcsp_pkg::CNT_MAX;
            rxc_q <= pcsp_pkg::CNT_MAX;
            rsh_q <= '0;
            rx_word_q <= '0;
            rx_tgl_q <= 1'b0;
        end else begin
            fsx_q <= tx_frame_sync;
            fsr_q <= rx_frame_sync;
            txc_q <= txc_d;
            rxc_q <= rxc_d;
            if (rx_win) begin
                rsh_q <= {rsh_q[6:0], rx_bit};
                if (rxc_d[2:0] == pcsp_pkg::LAST_BIT) begin
                    rx_word_q <= {rsh_q[6:0], rx_bit};
                    rx_tgl_q <= ~rx_tgl_q;
                end
            end
        end
    end

    // transmit: one bit per rising edge over the eight bit periods of the slot
    wire tx_win = bcfg_q.tx_en && in_slot(txc_q, bcfg_q.tx_slot,
                                          bcfg_q.delayed);
    logic [7:0] tsh_q;
    logic dx_q, dx_en_q, dx_port_q;
    always_ff @(posedge bit_clock) begin
        if (brst) begin
            tsh_q <= '0;
            dx_q <= 1'b0;
            dx_en_q <= 1'b0;
            dx_port_q <= 1'b0;
        end else begin
            dx_en_q <= tx_win;
            dx_port_q <= bcfg_q.tx_port;
            if (tx_win && txc_q[2:0] == 3'h0) begin
                dx_q <= tx_word_q[7];
                tsh_q <= {tx_word_q[6:0], 1'b0};
            end else if (tx_win) begin
                dx_q <= tsh_q[7];
                tsh_q <= {tsh_q[6:0], 1'b0};
            end
        end
    end
    wire [1:0] port_sel = dx_port_q ? 2'h2 : 2'h1;
    assign tx_pcm_out_o = {dx_q, dx_q};
    assign tx_pcm_out_oe = dx_en_q ? port_sel : 2'h0;
    assign slot_active_n_o = 2'h0;
    assign slot_active_n_oe = dx_en_q ? port_sel : 2'h0;

    // receive word back into sys domain
    logic [2:0] rxt_s_q;
    logic [7:0] rx_sample_q;
    logic rx_valid_q;
    always_ff @(posedge sys_clk) begin
        rxt_s_q <= {rxt_s_q[1:0], rx_tgl_q};
        if (rst_all) begin
            rx_sample_q <= '0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= rxt_s_q[2] != rxt_s_q[1];
            if (rxt_s_q[2] != rxt_s_q[1]) rx_sample_q <= rx_word_q;
        end
    end
    assign rx_sample = rx_sample_q;
    assign rx_sample_valid = rx_valid_q;
endmodule : pcsp_codec_ports

/* File: dv/pcsp_codec_ports_assertions.sv */
// port checks for the codec serial ports, bound into the top module
// assumes bit_clock edges never coincide with sys_clk edges
module pcsp_codec_ports_assertions (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic master_reset,
    input wire logic bit_clock,
    // pcm link
    input wire logic [1:0] tx_pcm_out_o,
    input wire logic [1:0] tx_pcm_out_oe,
    input wire logic [1:0] slot_active_n_o,
    input wire logic [1:0] slot_active_n_oe,
    // control port and coder side
    input wire logic control_clock,
    input wire logic control_cs_n,
    input wire logic control_serial_out_o,
    input wire logic control_serial_out_oe,
    input wire logic rx_sample_valid
);
    sequence s_slot;
        (|tx_pcm_out_oe)[*8] ##1 !(|tx_pcm_out_oe);
    endsequence
    sequence s_cs_idle;
        control_cs_n[*5];
    endsequence
    // link side leaves reset only after the master reset pin, so both count
    wire any_rst = sys_rst | master_reset;
    AST_TX_SLOT_LEN: assert property (@(posedge bit_clock)
        disable iff (any_rst)
        $rose(|tx_pcm_out_oe) |-> s_slot) else $error("slot length wrong");
    AST_TX_ONE_PORT: assert property (@(posedge sys_clk) disable iff (any_rst)
        !(&tx_pcm_out_oe)) else $error("both ports driven");
    AST_TX_RISE: assert property (@(posedge sys_clk) disable iff (any_rst)
        $changed(tx_pcm_out_o) |-> bit_clock && !$past(bit_clock))
        else $error("tx bit off rising edge");
    AST_IND_FOLLOW: assert property (@(posedge sys_clk) disable iff (any_rst)
        slot_active_n_oe == tx_pcm_out_oe) else $error("indicator wrong");
    AST_IND_LOW: assert property (@(posedge sys_clk) disable iff (any_rst)
        |slot_active_n_oe |-> slot_active_n_o == 2'h0)
        else $error("indicator not low");
    AST_CS_FLOAT: assert property (@(posedge sys_clk) disable iff (any_rst)
        s_cs_idle |-> !control_serial_out_oe) else $error("out not off");
    AST_CS_DRIVE: assert property (@(posedge sys_clk) disable iff (any_rst)
        (!control_cs_n)[*5] |-> control_serial_out_oe)
        else $error("out not on");
    AST_CO_RISE: assert property (@(posedge sys_clk) disable iff (any_rst)
        $changed(control_serial_out_o) && !control_cs_n
        && $past(!control_cs_n, 6) |-> control_clock)
        else $error("readback off rising edge");
    AST_RX_PULSE: assert property (@(posedge sys_clk) disable iff (any_rst)
        rx_sample_valid |=> !rx_sample_valid[*8])
        else $error("byte pulses too close");
endmodule : pcsp_codec_ports_assertions

bind pcsp_codec_ports pcsp_codec_ports_assertions u_chk (.sys_clk, .sys_rst,
    .master_reset, .bit_clock, .tx_pcm_out_o, .tx_pcm_out_oe, .slot_active_n_o,
    .slot_active_n_oe, .control_clock, .control_cs_n, .control_serial_out_o,
    .control_serial_out_oe, .rx_sample_valid);

/* File: dv/pcsp_pcm_partner.sv */
// backplane model: bit clock, frame sync, receive data, transmit capture
// assumes pulled-up transmit and slot indicator lines
module pcsp_pcm_partner #(
    parameter int FRAME_BITS = 512
) (
    // link
    output logic bit_clock,
    output logic frame_sync,
    output logic [1:0] rx_line,
    input wire logic [1:0] tx_line,
    input wire logic [1:0] slot_line_n,
    // test control and results
    input wire logic [9:0] rx_first,
    input wire logic rx_port,
    input wire logic [7:0] rx_byte,
    output logic [7:0] tx_got,
    output logic tx_got_port,
    output logic tx_got_stb
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] cnt_q;
    logic [9:0] nxt;
    logic [9:0] idx;
    logic [7:0] sh_q;
    logic [2:0] n_q;
    logic p;
    assign nxt = (cnt_q == 10'(FRAME_BITS - 1)) ? 10'h000 : cnt_q + 10'h001;
    assign idx = nxt - rx_first;
    assign p = !slot_line_n[1];
    initial begin
        {bit_clock, cnt_q, n_q, frame_sync, tx_got_stb} = '0;
        rx_line = 2'h0;
        // one time-scaled clock serves as bit and master clock
        #1.3;
        forever #32 bit_clock = ~bit_clock;
    end
    always @(posedge bit_clock) begin
        cnt_q <= nxt;
        frame_sync <= (nxt == 10'h000);
        // other port carries the inverted byte and idle bits toggle so stray sampling shows
        if (idx < 10'h008) begin
            rx_line[rx_port] <= rx_byte[3'h7 - idx[2:0]];
            rx_line[!rx_port] <= !rx_byte[3'h7 - idx[2:0]];
        end else begin
            rx_line <= {cnt_q[0], !cnt_q[0]};
        end
    end
    // line driver enabled by the slot indicator, as on a backplane
    always @(negedge bit_clock) begin
        tx_got_stb <= (slot_line_n !== 2'h3) && (n_q == 3'h7);
        if (slot_line_n !== 2'h3) begin
            sh_q <= {sh_q[6:0], tx_line[p]};
            n_q <= n_q + 3'h1;
            if (n_q == 3'h7) begin
                tx_got <= {sh_q[6:0], tx_line[p]};
                tx_got_port <= p;
            end
        end
    end
endmodule : pcsp_pcm_partner

/* File: dv/pcsp_codec_ports_tb_top.sv */
// bench for the codec ports: control frames, latches, pcm slots
// assumes the backplane model drives the link side
module pcsp_codec_ports_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic master_reset = 1'b1;
    logic control_clock = 1'b0;
    logic control_serial_in = 1'b0;
    logic control_cs_n = 1'b1;
    logic [5:0] latch_pin_i = 6'h00;
    logic [7:0] tx_sample = 8'h00;
    logic tx_sample_load = 1'b0;
    logic [9:0] rx_first = 10'h000;
    logic rx_port = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [1:0] tx_pcm_out_o, tx_pcm_out_oe, slot_active_n_o, slot_active_n_oe;
    logic [1:0] rx_line, tx_line, slot_line_n;
    logic [5:0] latch_pin_o, latch_pin_oe;
    logic [7:0] rx_sample, tx_got, rd;
    logic control_serial_out_o, control_serial_out_oe, rx_sample_valid;
    logic mu_law_sel, bit_clock, frame_sync, tx_got_port, tx_got_stb;
    int bad_count = 0;
    int checks_done = 0;
    logic [8:0] q_rx[$];
    logic [8:0] q_tx[$];
    always #2 sys_clk = ~sys_clk;
    assign tx_line = tx_pcm_out_o | ~tx_pcm_out_oe;
    assign slot_line_n = slot_active_n_o | ~slot_active_n_oe;
    pcsp_codec_ports dut (.sys_clk, .sys_rst, .master_reset, .bit_clock,
        .tx_frame_sync(frame_sync), .rx_frame_sync(frame_sync),
        .rx_pcm_in_port0(rx_line[0]), .rx_pcm_in_port1(rx_line[1]),
        .tx_pcm_out_o, .tx_pcm_out_oe, .slot_active_n_o, .slot_active_n_oe,
        .control_clock, .control_serial_in, .control_cs_n,
        .control_serial_out_o, .control_serial_out_oe, .latch_pin_i,
        .latch_pin_o, .latch_pin_oe, .tx_sample, .tx_sample_load,
        .rx_sample, .rx_sample_valid, .mu_law_sel);
    pcsp_pcm_partner u_bp (.bit_clock, .frame_sync, .rx_line, .tx_line,
        .slot_line_n, .rx_first, .rx_port, .rx_byte, .tx_got, .tx_got_port,
        .tx_got_stb);
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // clock high and low phases of 8 cycles each, msb first
    task automatic ctl(input logic [15:0] frm, input int nb);
        control_cs_n = 1'b0;
        tick(8);
        for (int i = 0; i < nb; i++) begin
            control_clock = 1'b1;
            control_serial_in = frm[15 - i];
            tick(8);
            if (i > 7) rd[15 - i] = control_serial_out_o;
            control_clock = 1'b0;
            tick(8);
        end
        control_cs_n = 1'b1;
        tick(8);
    endtask : ctl
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ctl({5'h00, a, d}, 16);
    endtask : wr
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        ctl({5'h10, a, 8'h00}, 16);
        check({1'b0, rd}, {1'b0, e});
    endtask : rdchk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    always @(negedge sys_clk) begin
        if (rx_sample_valid === 1'b1) begin
            check({1'b0, rx_sample}, q_rx.size() ? q_rx.pop_front() : 'x);
        end
    end
    always @(posedge tx_got_stb) begin
        check({tx_got_port, tx_got}, q_tx.size() ? q_tx.pop_front() : 'x);
    end
    initial begin
        #350000;
        bad_count++;
        wrap_up();
    end
    initial begin
        logic [7:0] v;
        logic [7:0] dir;
        logic [7:0] sl;
        v = 8'($urandom(32'hac3b455e));
        tick(6);
        sys_rst = 1'b0;
        tick(58);
        master_reset = 1'b0;
        tick(8);
        for (int m = 0; m < 2; m++) begin
            wr(pcsp_pkg::A_MODE, 8'(m));
            rdchk(pcsp_pkg::A_MODE, 8'(m));
            check({8'h00, mu_law_sel}, 9'(m));
        end
        ctl({5'h00, pcsp_pkg::A_MODE, 8'h0e}, 12);
        wr(3'h6, 8'h00);
        rdchk(pcsp_pkg::A_MODE, 8'h01);
        rdchk(3'h5, 8'h00);
        dir = 8'($urandom) & 8'h3f;
        v = 8'($urandom);
        latch_pin_i = 6'($urandom);
        wr(pcsp_pkg::A_LATCH_DIR, dir);
        wr(pcsp_pkg::A_LATCH_VAL, v);
        check({3'h0, latch_pin_oe}, {3'h0, dir[5:0]});
        check({3'h0, latch_pin_o}, {3'h0, v[5:0]});
        v = (v & dir) | ({2'h0, latch_pin_i} & ~dir);
        latch_pin_i = ~latch_pin_i;
        ctl({5'h10, pcsp_pkg::A_LATCH_VAL, 8'h00}, 16);
        check({3'h0, rd[5:0]}, {3'h0, v[5:0]});
        // slots of 8 or more leave time to program inside the frame;
        // the last pass is non-delayed, its slot opens at the sync
        for (int c = 0; c < 4; c++) begin
            sl = (c == 0) ? 8'h3f : (c == 1) ? 8'h08 : 8'(9 + $urandom % 54);
            sl[6] = c[0];
            rx_first = (c == 3) ? 10'h000 : {sl[6:0], 3'h0} & 10'h1f8;
            rx_port = c[0];
            rx_byte = 8'($urandom);
            tx_sample = 8'($urandom);
            @(posedge frame_sync);
            tick(1);
            tx_sample_load = 1'b1;
            tick(1);
            tx_sample_load = 1'b0;
            q_tx.push_back({c[0], tx_sample});
            q_rx.push_back({1'b0, rx_byte});
            wr(pcsp_pkg::A_TX_SLOT, sl);
            wr(pcsp_pkg::A_RX_SLOT, sl);
            wr(pcsp_pkg::A_MODE, (c == 3) ? 8'h0c : 8'h0e);
            @(posedge frame_sync);
            tick(1);
            wr(pcsp_pkg::A_MODE, 8'h02);
        end
        check(9'(q_tx.size() + q_rx.size()), 9'h000);
        wrap_up();
    end
endmodule : pcsp_codec_ports_tb_top
